// *** pad_drive_and_function_select.sv ***
// Chosen here: the APB slave port and the placing of the registers.
`default_nettype none
// What this block does
// - four drive levels via three registers
// - two-bit code 00 weakest, 11 strongest
// - level reg0 upper bits drive port b
// - level reg0 lower bits drive port a
// - level reg1 upper bits drive port d
// - level reg1 lower bits drive port c
// - level reg2 covers port f and e
// - output and input function select registers
// - direction one input readable, zero push-pull output
// - function code 11 alone routes alternate
module pad_drive_and_function_select
  import pad_mux_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [47:0] i_pad_in,
  output logic [47:0] o_pad_oe_n,
  output logic [23:0] o_drive_level,
  output logic [119:0] o_func_sel,
  output logic [47:0] o_alt_route
);
  logic [7:0] drive_reg [3];
  logic [7:0] next_drive_reg [3];
  logic [7:0] func_reg [NUM_FUNC_REGS];
  logic [7:0] next_func_reg [NUM_FUNC_REGS];
  logic [7:0] dir_reg [NUM_PORTS];
  logic [7:0] next_dir_reg [NUM_PORTS];
  logic [47:0] pad_meta;
  logic [47:0] pad_sync;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic next_pready;
  // pad-facing next values, one continuous driver per slice
  wire logic [47:0] next_pad_oe_n;
  wire logic [119:0] next_func_sel;
  wire logic [47:0] next_alt_route;
  wire logic [23:0] next_drive_level;
  logic access;

  // address decode results
  logic drive_hit;
  logic func_hit;
  logic dir_hit;
  logic pin_hit;
  logic [1:0] drive_idx;
  logic [3:0] func_idx;
  logic [2:0] port_idx;
  logic [7:0] func_off;
  logic [7:0] dir_off;
  logic [7:0] pin_off;

  // drive level of each pin group, taken from the next register state
  wire logic [1:0] lvl_a_lo;
  wire logic [1:0] lvl_a_hi;
  wire logic [1:0] lvl_b_lo;
  wire logic [1:0] lvl_b_hi;
  wire logic [1:0] lvl_c_lo;
  wire logic [1:0] lvl_c_hi;
  wire logic [1:0] lvl_d_lo;
  wire logic [1:0] lvl_d_hi;
  wire logic [1:0] lvl_e_lo;
  wire logic [1:0] lvl_e_hi;
  wire logic [1:0] lvl_f_lo;
  wire logic [1:0] lvl_f_hi;

  // register map, byte addresses on the bus:
  //   drive level words at the three drive addresses
  //   fifteen function words from the function base, one word apart
  //     order: a0 a1 b0 b1 c0 c1 d0 d1 e0 e1 f0 f1 then three input selects
  //   six direction words from the direction base, ports a to f
  //   six read-only pin-state words from the pin-state base
  // anything else, or any misaligned address, answers with an error
  // and leaves every register untouched

  // access phase; one wait state, pready asserted on the following edge
  // the pready term stops the held request from being taken twice
  assign access = i_psel && i_penable && !o_pready;

  // offsets from each window base; wrap below a base is caught by the range test
  assign func_off = i_paddr - ADDR_FUNC_BASE;
  assign dir_off = i_paddr - ADDR_DIR_BASE;
  assign pin_off = i_paddr - ADDR_PIN_STATE_BASE;

  // address decode; at most one window hits
  always_comb begin
    drive_hit = 1'b0;
    func_hit = 1'b0;
    dir_hit = 1'b0;
    pin_hit = 1'b0;
    drive_idx = 2'h0;
    func_idx = 4'h0;
    port_idx = 3'h0;
    if (i_paddr == ADDR_DRIVE_LEVEL_SEL_0) begin
      drive_hit = 1'b1;
      drive_idx = 2'h0;
    end else if (i_paddr == ADDR_DRIVE_LEVEL_SEL_1) begin
      drive_hit = 1'b1;
      drive_idx = 2'h1;
    end else if (i_paddr == ADDR_DRIVE_LEVEL_SEL_2) begin
      drive_hit = 1'b1;
      drive_idx = 2'h2;
    end else if (i_paddr[1:0] != 2'h0) begin
      // misaligned: no window, the access ends in an error
      drive_hit = 1'b0;
    end else if (i_paddr >= ADDR_FUNC_BASE &&
                 i_paddr < ADDR_FUNC_BASE + 8'(4 * NUM_FUNC_REGS)) begin
      func_hit = 1'b1;
      func_idx = func_off[5:2];
    end else if (i_paddr >= ADDR_DIR_BASE &&
                 i_paddr < ADDR_DIR_BASE + 8'(4 * NUM_PORTS)) begin
      dir_hit = 1'b1;
      port_idx = dir_off[4:2];
    end else if (i_paddr >= ADDR_PIN_STATE_BASE &&
                 i_paddr < ADDR_PIN_STATE_BASE + 8'(4 * NUM_PORTS)) begin
      pin_hit = 1'b1;
      port_idx = pin_off[4:2];
    end
  end

  // register next values and read mux
  always_comb begin
    next_drive_reg = drive_reg;
    next_func_reg = func_reg;
    next_dir_reg = dir_reg;
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    next_pready = access;
    if (access) begin
      if (drive_hit) begin
        if (i_pwrite) begin
          // all eight bits are implemented, nothing to mask
          next_drive_reg[drive_idx] = i_pwdata[7:0];
        end else begin
          next_prdata = {24'h000000, drive_reg[drive_idx]};
        end
      end else if (func_hit) begin
        if (i_pwrite) begin
          // unimplemented bits dropped so they always read zero
          next_func_reg[func_idx] = i_pwdata[7:0] & FUNC_MASK[func_idx];
        end else begin
          next_prdata = {24'h000000, func_reg[func_idx]};
        end
      end else if (dir_hit) begin
        if (i_pwrite) begin
          // absent pins keep a zero bit; their driver is released anyway
          next_dir_reg[port_idx] = i_pwdata[7:0] & PORT_MASK[port_idx];
        end else begin
          next_prdata = {24'h000000, dir_reg[port_idx]};
        end
      end else if (pin_hit && !i_pwrite) begin
        // input pins show the synchronised pad level; output pins read zero
        next_prdata = {24'h000000, pad_sync[port_idx*8 +: 8] & dir_reg[port_idx]};
      end else begin
        next_pslverr = 1'b1; // unmapped, misaligned or write to read-only
        next_prdata = PSLVERR_NONE;
      end
    end
  end

  // drive level word 0: port a in the low nibble, port b in the high one
  assign lvl_a_lo = next_drive_reg[0][1:0];
  assign lvl_a_hi = next_drive_reg[0][3:2];
  assign lvl_b_lo = next_drive_reg[0][5:4];
  assign lvl_b_hi = next_drive_reg[0][7:6];

  // drive level word 1: port c low, port d high (port d has pins 6..0)
  assign lvl_c_lo = next_drive_reg[1][1:0];
  assign lvl_c_hi = next_drive_reg[1][3:2];
  assign lvl_d_lo = next_drive_reg[1][5:4];
  assign lvl_d_hi = next_drive_reg[1][7:6];

  // drive level word 2: port e low, its hi field serves pin 4 alone
  assign lvl_e_lo = next_drive_reg[2][1:0];
  assign lvl_e_hi = next_drive_reg[2][3:2];
  assign lvl_f_lo = next_drive_reg[2][5:4];
  assign lvl_f_hi = next_drive_reg[2][7:6];

  // codes pass to the pads unchanged: 00 weakest up to 11 strongest
  // built from next state so the pads move on the write edge itself
  assign next_drive_level = {lvl_f_hi, lvl_f_lo, lvl_e_hi, lvl_e_lo,
                             lvl_d_hi, lvl_d_lo, lvl_c_hi, lvl_c_lo,
                             lvl_b_hi, lvl_b_lo, lvl_a_hi, lvl_a_lo};

  // raw function fields, one byte per register
  for (genvar r = 0; r < NUM_FUNC_REGS; r++) begin : g_func_field
    assign next_func_sel[r*8 +: 8] = next_func_reg[r];
  end

  // direction high releases the driver; absent pins stay released
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port_oe
    assign next_pad_oe_n[p*8 +: 8] = next_dir_reg[p] | ~PORT_MASK[p];
  end

  // pin n of port p: register 2p + n/4, field n%4; only 11 routes alternate
  // masked fields read zero, so absent pins never route
  for (genvar g = 0; g < 8 * NUM_PORTS; g++) begin : g_alt_pin
    assign next_alt_route[g] =
      (next_func_reg[2 * (g / 8) + (g % 8) / 4][2 * (g % 4) +: 2] == FUNC_ALT_CODE);
  end

  // registers; drive/func zero at reset, direction all input
  // every output is a flop, so the pads never see decode glitches
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < 3; i++) begin
        drive_reg[i] <= DRIVE_RESET;
      end
      for (int i = 0; i < NUM_FUNC_REGS; i++) begin
        func_reg[i] <= FUNC_RESET;
      end
      for (int i = 0; i < NUM_PORTS; i++) begin
        dir_reg[i] <= DIR_RESET & PORT_MASK[i];
      end
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_drive_level <= '0;
      o_func_sel <= '0;
      o_alt_route <= '0;
      o_pad_oe_n <= '1;
      pad_meta <= '0;
      pad_sync <= '0;
    end else begin
      drive_reg <= next_drive_reg;
      func_reg <= next_func_reg;
      dir_reg <= next_dir_reg;
      o_prdata <= next_prdata;
      o_pready <= next_pready;
      o_pslverr <= next_pslverr;
      o_drive_level <= next_drive_level;
      o_func_sel <= next_func_sel;
      o_alt_route <= next_alt_route;
      o_pad_oe_n <= next_pad_oe_n;
      pad_meta <= i_pad_in; // two-stage sync of the pad levels
      pad_sync <= pad_meta;
    end
  end
endmodule : pad_drive_and_function_select
`default_nettype wire

// *** pad_mux_pkg.sv ***
`default_nettype none
package pad_mux_pkg;
  // register byte addresses on the apb slave
  localparam logic [7:0] ADDR_DRIVE_LEVEL_SEL_0 = 8'h00;
  localparam logic [7:0] ADDR_DRIVE_LEVEL_SEL_1 = 8'h04;
  localparam logic [7:0] ADDR_DRIVE_LEVEL_SEL_2 = 8'h08;
  localparam logic [7:0] ADDR_FUNC_BASE = 8'h10;
  localparam logic [7:0] ADDR_DIR_BASE = 8'h60;
  localparam logic [7:0] ADDR_PIN_STATE_BASE = 8'h80;
  // function select count: two output per port for six ports, plus three input selects
  localparam int NUM_FUNC_REGS = 15;
  localparam int NUM_PORTS = 6;
  // implemented bit masks, same order as the function register index
  localparam logic [7:0] FUNC_MASK [NUM_FUNC_REGS] = '{
    8'hCC, 8'hFF, 8'hFF, 8'hF3, 8'hFF, 8'hFF, 8'hFF, 8'h3F,
    8'hFF, 8'h03, 8'hFF, 8'hFF, 8'h7F, 8'h7F, 8'h07};
  // pins present per port a..f
  localparam logic [7:0] PORT_MASK [NUM_PORTS] = '{
    8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h1F, 8'hFF};
  localparam logic [7:0] DRIVE_RESET = 8'h00;
  localparam logic [7:0] FUNC_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic [1:0] FUNC_ALT_CODE = 2'h3;
  localparam logic [31:0] PSLVERR_NONE = 32'h0000_0000;
endpackage : pad_mux_pkg
`default_nettype wire

// *** pad_drive_props.sv ***
`default_nettype none
module pad_drive_props
  import pad_mux_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [23:0] o_drive_level,
  input wire logic [119:0] o_func_sel,
  input wire logic [47:0] o_alt_route
);
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (!i_nrst);
  // accepted write, seen on the acknowledge cycle
  wire logic wr = o_pready && i_pwrite && !o_pslverr;
  a_wait_one: assert property ($rose(i_penable) |=> o_pready) else $error("no answer");
  a_ack_pulse: assert property (o_pready |=> !o_pready) else $error("long ack");
  a_lvl_zero: assert property (wr && i_paddr == ADDR_DRIVE_LEVEL_SEL_0 |->
    o_drive_level[7:0] == i_pwdata[7:0]) else $error("level 0");
  a_lvl_one: assert property (wr && i_paddr == ADDR_DRIVE_LEVEL_SEL_1 |->
    o_drive_level[15:8] == i_pwdata[7:0]) else $error("level 1");
  a_lvl_two: assert property (wr && i_paddr == ADDR_DRIVE_LEVEL_SEL_2 |->
    o_drive_level[23:16] == i_pwdata[7:0]) else $error("level 2");
  // pads may only move on a write, never drift
  a_lvl_hold: assert property (!$stable(o_drive_level) |-> wr) else $error("drift");
  a_alt_code: assert property (o_alt_route[4] == (o_func_sel[9:8] == FUNC_ALT_CODE) &&
    o_alt_route[1] == (o_func_sel[3:2] == FUNC_ALT_CODE)) else $error("alt route");
  a_gap_zero: assert property (o_func_sel[5:4] == 2'h0 && !o_alt_route[0]) else $error("gap");
  a_read_wide: assert property (o_pready && !i_pwrite |-> o_prdata[31:8] == 24'h0)
    else $error("read upper");
  cover property (wr && i_paddr == ADDR_DRIVE_LEVEL_SEL_2);
  cover property (o_pslverr);
  cover property (o_alt_route[4]);
endmodule : pad_drive_props
`default_nettype wire

// *** test_pad_drive_and_function_select.sv ***
`default_nettype none
module test_pad_drive_and_function_select;
  timeunit 1ns;
  timeprecision 1ps;
  import pad_mux_pkg::*;
  logic i_core_clk, i_nrst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, e;
  logic [7:0] i_paddr, d;
  logic [31:0] i_pwdata, o_prdata, r;
  logic [47:0] i_pad_in, o_pad_oe_n, o_alt_route;
  logic [23:0] o_drive_level, dl;
  logic [119:0] o_func_sel;
  int num_errors, n_checks, i;
  pad_drive_and_function_select u_pad_drive_and_function_select (.*);
  // 40 mhz
  always #12.5 i_core_clk = ~i_core_clk;
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
    n_checks++;
    if (y !== x) begin
      $display("[FAIL] %s exp %h got %h", nm, x, y);
      num_errors++;
    end
  endtask : chk
  // request held until pready is sampled high; bounded wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] v);
    int n;
    @(posedge i_core_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= {24'h0, v};
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_core_clk);
      n++;
      if (n > 16) begin
        num_errors++;
        wrap_up;
      end
    end while (o_pready !== 1'b1);
    r = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  function automatic logic [3:0] alt_of(input logic [7:0] v);
    for (int k = 0; k < 4; k++) alt_of[k] = (v[2*k+:2] == FUNC_ALT_CODE);
  endfunction : alt_of
  initial begin
    {i_core_clk, i_nrst, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
    num_errors = 0;
    n_checks = 0;
    dl = '0;
    i = $urandom(32'hC7EB);
    i_pad_in = {16'($urandom), $urandom};
    repeat (10) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    for (i = 0; i < 3; i++) begin
      apb(1'b0, 8'(4 * i), 8'h00);
      chk("drive reset", 32'h0, r);
    end
    // all ones, all zeros, then random codes
    for (i = 0; i < 12; i++) begin
      d = (i < 3) ? 8'hFF : (i < 6) ? 8'h00 : 8'($urandom);
      dl[8*(i%3)+:8] = d;
      apb(1'b1, 8'(4 * (i % 3)), d);
      chk("drive pads", 32'(dl), 32'(o_drive_level));
      apb(1'b0, 8'(4 * (i % 3)), 8'h00);
      chk("drive read", 32'(d), r);
    end
    // unimplemented bits must not stick
    apb(1'b1, ADDR_FUNC_BASE, 8'hFF);
    apb(1'b0, ADDR_FUNC_BASE, 8'h00);
    chk("pa0 read", 32'hCC, r);
    chk("pa0 alt", 32'hA, 32'(o_alt_route[3:0]));
    for (i = 0; i < 8; i++) begin
      d = (i < 4) ? {4{2'(i)}} : 8'($urandom);
      apb(1'b1, ADDR_FUNC_BASE + 8'h04, d);
      chk("pa1 alt", 32'(alt_of(d)), 32'(o_alt_route[7:4]));
    end
    apb(1'b1, ADDR_DIR_BASE, 8'h00);
    chk("pa dir", 32'h0, 32'(o_pad_oe_n[7:0]));
    apb(1'b1, ADDR_DIR_BASE + 8'h0C, 8'h00);
    chk("pd dir", 32'h80, 32'(o_pad_oe_n[31:24]));
    apb(1'b0, ADDR_PIN_STATE_BASE, 8'h00);
    chk("pa pins", 32'h0, r);
    apb(1'b1, ADDR_DIR_BASE + 8'h04, 8'hFF);
    apb(1'b0, ADDR_PIN_STATE_BASE + 8'h04, 8'h00);
    chk("pb pins", 32'(i_pad_in[15:8]), r);
    apb(1'b1, ADDR_FUNC_BASE + 8'h2C, 8'hC0);
    chk("pf7 alt", 32'h1, 32'(o_alt_route[47]));
    apb(1'b1, 8'hFC, 8'h55);
    chk("unmapped", 32'h1, 32'(e));
    wrap_up;
  end
endmodule : test_pad_drive_and_function_select
bind pad_drive_and_function_select pad_drive_props u_pad_drive_props (.*);
`default_nettype wire
